// *** bench/csio_asserts.sv ***
// port assertions for the clocked serial i/o unit
`timescale 1ns/100ps
`default_nettype none
module csio_asserts
  import csio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] sel_rdata,
  input wire logic [3:0] mode_rdata,
  input wire logic irq,
  input wire logic sck_clk,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic shared_oe,
  input wire logic dedicated_oe
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic sck_q; // pin level a cycle back
  logic run_q; // run readback a cycle back
  logic [3:0] nfall; // pin falls since run rose
  // count falls; a fresh start clears the count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b1;
      run_q <= 1'b0;
      nfall <= 4'h0;
    end else begin
      sck_q <= sck_clk;
      run_q <= mode_rdata[0];
      if (mode_rdata[0] && !run_q) begin
        nfall <= 4'h0;
      end else if (sck_q && !sck_clk) begin
        nfall <= nfall + 4'h1;
      end
    end
  end
  // ****************
  // assertions
  // ****************
  sck_drive_a: assert property (
    ($stable(sel_rdata))[*3] |-> sck_oe == (sel_rdata[1:0] != 2'h0))
    else $error("clock drive does not follow select");
  pin_role_a: assert property (
    ($stable(mode_rdata))[*3] |-> shared_oe == (mode_rdata[3] && !mode_rdata[1])
      && dedicated_oe == mode_rdata[1]) else $error("data pin roles wrong");
  wait_high_a: assert property (
    (sck_oe && !mode_rdata[0])[*4] |-> sck_out)
    else $error("clock not high in wait");
  irq_pulse_a: assert property (irq |=> !irq)
    else $error("request longer than one cycle");
  end_clears_run_a: assert property (
    irq |-> ##[0:3] !mode_rdata[0]) else $error("run flag kept after end");
  eight_falls_a: assert property (irq |-> nfall == 4'h8)
    else $error("request without eight clocks");
  count_bound_a: assert property (nfall <= 4'h8)
    else $error("more than eight clocks in a frame");
  rate_locked_a: assert property (
    mode_rdata[0] && $past(mode_rdata[0]) |-> $stable(sel_rdata))
    else $error("rate changed while running");
endmodule : csio_asserts
bind csio_top csio_asserts chk (.sys_clk(sys_clk), .rst(rst),
  .sel_rdata(sel_rdata), .mode_rdata(mode_rdata), .irq(irq), .sck_clk(sck_clk),
  .sck_out(sck_out), .sck_oe(sck_oe), .shared_oe(shared_oe),
  .dedicated_oe(dedicated_oe));
`default_nettype wire

// *** bench/csio_peer.sv ***
// model of the external serial device on the clock and data pins
`timescale 1ns/100ps
`default_nettype none
module csio_peer (
  input wire logic lclk,
  input wire logic sck_pin,
  input wire logic data_pin,
  input wire logic arm,
  input wire logic slave,
  input wire logic [7:0] tx_byte,
  output logic sck_drv,
  output logic sck_en,
  output logic data_drv,
  output logic [7:0] rx_byte
);
  logic [2:0] bit_n; // bits sent this frame
  initial begin
    sck_drv = 1'b1;
    sck_en = 1'b0;
    data_drv = 1'b0;
    rx_byte = 8'h00;
    bit_n = 3'h0;
  end
  // a frame restarts the count; facing a slave we make the clock
  always @(posedge arm) begin
    bit_n = 3'h0;
    if (slave) begin
      @(posedge lclk) sck_en <= 1'b1;
      repeat (8) begin
        @(posedge lclk) sck_drv <= 1'b0;
        @(posedge lclk) sck_drv <= 1'b1;
      end
      // clock stands still between frames
      @(posedge lclk) sck_en <= 1'b0;
    end
  end
  always @(negedge sck_pin) begin
    data_drv <= tx_byte[~bit_n];
    bit_n <= bit_n + 3'h1;
  end
  // sample late: the unit's out bit lags the fall
  always @(posedge sck_pin) begin
    #40;
    rx_byte = {rx_byte[6:0], data_pin};
  end
endmodule : csio_peer
`default_nettype wire

// *** bench/csio_tb_top.sv ***
// self-checking bench for the clocked serial i/o unit
`timescale 1ns/100ps
`default_nettype none
module csio_tb_top;
  import csio_pkg::*;
  logic sys_clk, rst, lclk, sel_wr, mode_wr, put_wr, clock_stop;
  logic [3:0] sel_wdata, mode_wdata, sel_rdata, mode_rdata;
  logic [7:0] put_data, get_data, ptx, prx;
  logic irq, sck_out, sck_oe, shared_out, shared_oe, dedicated_out, dedicated_oe;
  logic arm, slave, talk, psck, psck_en, pdat; // partner side
  int err_total, samples_checked, cyc;
  // clock pin pulled up; a released data pin toggles every half cycle
  wire sck_w = sck_oe ? sck_out : (psck_en ? psck : 1'b1);
  wire shared_w = shared_oe ? shared_out : (talk ? pdat : sys_clk);
  wire ser_w = dedicated_oe ? dedicated_out : shared_w;
  csio_top uut (.sys_clk(sys_clk), .rst(rst), .sel_wr(sel_wr),
    .sel_wdata(sel_wdata), .sel_rdata(sel_rdata), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .mode_rdata(mode_rdata), .put_wr(put_wr),
    .put_data(put_data), .get_data(get_data), .clock_stop(clock_stop),
    .irq(irq), .sck_clk(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .shared_in(shared_w), .shared_out(shared_out), .shared_oe(shared_oe),
    .dedicated_out(dedicated_out), .dedicated_oe(dedicated_oe));
  csio_peer peer (.lclk(lclk), .sck_pin(sck_w), .data_pin(ser_w), .arm(arm),
    .slave(slave), .tx_byte(ptx), .sck_drv(psck), .sck_en(psck_en),
    .data_drv(pdat), .rx_byte(prx));
  // 20 ns system clock; 80 ns link clock at an unrelated phase
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #40 lclk = ~lclk;
  end
  // a hang ends the run as a mismatch
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      $display("[ERR] run_length exp %0d got %0d", 59999, cyc);
      err_total++;
      tally_and_finish();
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk_v(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask : chk_v
  task automatic chk_n(input string n, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      $display("[ERR] %s exp %0d got %0d", n, e, g);
      err_total++;
    end
  endtask : chk_n
  task automatic wr(input logic [3:0] s, input logic sw, input logic [3:0] m,
    input logic mw);
    @(negedge sys_clk);
    {sel_wr, sel_wdata, mode_wr, mode_wdata} = {sw, s, mw, m};
    @(negedge sys_clk);
    {sel_wr, mode_wr} = 2'h0;
  endtask : wr
  task automatic buffer_store_instruction(input logic [7:0] d);
    @(negedge sys_clk);
    {put_wr, put_data} = {1'b1, d};
    @(negedge sys_clk);
    put_wr = 1'b0;
  endtask : buffer_store_instruction
  // load in wait, then start and pick the clock in one write
  task automatic start(input logic [3:0] s, m, input logic [7:0] ld, tx,
    input logic sl);
    buffer_store_instruction(ld);
    {ptx, slave, talk} = {tx, sl, !m[3]};
    wr(s, 1'b1, m, 1'b1);
    repeat (2) @(negedge sys_clk);
    arm = 1'b1;
    @(negedge sys_clk);
    arm = 1'b0;
  endtask : start
  task automatic finish();
    int i;
    for (i = 0; i < 20000 && irq !== 1'b1; i++)
      @(negedge sys_clk);
    chk_n("irq_seen", 1, (i < 20000) ? 1 : 0);
    repeat (4) @(negedge sys_clk);
  endtask : finish
  task automatic wait_low();
    int i;
    for (i = 0; i < 2000 && sck_out !== 1'b0; i++)
      @(negedge sys_clk);
  endtask : wait_low
  // ****************
  // scenarios
  // ****************
  task automatic t_codes();
    int c;
    chk_v("rdata", 8'h00, {sel_rdata, mode_rdata});
    chk_v("idle_pins", 8'h01, {3'h0, irq, sck_oe, shared_oe, dedicated_oe, sck_out});
    for (c = 0; c < 4; c++) begin
      wr(c[3:0], 1'b1, 4'h0, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk_v("sel", {6'h0, c[1:0]}, {4'h0, sel_rdata});
      chk_v("sck_oe", {7'h0, c != 0}, {7'h0, sck_oe});
    end
    wr(4'h0, 1'b0, 4'hE, 1'b1);
    repeat (3) @(negedge sys_clk);
    chk_v("mode", 8'h0A, {4'h0, mode_rdata});
    chk_v("oe_3w", 8'h01, {6'h0, shared_oe, dedicated_oe});
    wr(4'h0, 1'b0, 4'h8, 1'b1);
    repeat (3) @(negedge sys_clk);
    chk_v("oe_2w", 8'h02, {6'h0, shared_oe, dedicated_oe});
    $display("code test done");
  endtask : t_codes
  task automatic t_master();
    int n;
    start(4'h3, 4'h3, 8'hA5, 8'h3C, 1'b0);
    wait_low();
    for (n = 0; n < 2000 && sck_out === 1'b0; n++)
      @(negedge sys_clk);
    chk_n("half_period", 50000000 / (2 * 37500), n);
    wr(4'h0, 1'b0, 4'h3, 1'b1);
    finish();
    chk_v("rx_3w", 8'hA5, prx);
    chk_v("get_3w", 8'h3C, get_data);
    chk_v("end_3w", 8'h12, {3'h0, sck_out, mode_rdata});
    $display("master test done");
  endtask : t_master
  task automatic t_slave();
    start(4'h0, 4'h9, 8'h96, 8'h00, 1'b1);
    finish();
    chk_v("rx_2w", 8'h96, prx);
    chk_v("loop_2w", 8'h96, get_data);
    start(4'h0, 4'h1, 8'h00, 8'hC3, 1'b1);
    finish();
    chk_v("get_2w", 8'hC3, get_data);
    chk_v("run_2w", 8'h00, {4'h0, mode_rdata});
    $display("slave test done");
  endtask : t_slave
  task automatic t_stop();
    start(4'h3, 4'h3, 8'h00, 8'hFF, 1'b0);
    wait_low();
    // the fall needs a few cycles to cross before a load counts as live
    repeat (4) @(negedge sys_clk);
    buffer_store_instruction(8'h80);
    repeat (3) @(negedge sys_clk);
    chk_v("live_one", 8'h01, {7'h0, dedicated_out});
    buffer_store_instruction(8'h7F);
    repeat (3) @(negedge sys_clk);
    chk_v("live_zero", 8'h00, {7'h0, dedicated_out});
    wr(4'h0, 1'b0, 4'h2, 1'b1);
    repeat (3) @(negedge sys_clk);
    chk_v("forced", 8'h12, {3'h0, sck_out, mode_rdata});
    start(4'h3, 4'h3, 8'h00, 8'hFF, 1'b0);
    wait_low();
    @(negedge sys_clk);
    clock_stop = 1'b1;
    @(negedge sys_clk);
    clock_stop = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk_v("stopped", 8'h12, {3'h0, sck_out, mode_rdata});
    start(4'h3, 4'h3, 8'h5A, 8'h81, 1'b0);
    finish();
    chk_v("rx_after", 8'h5A, prx);
    chk_v("get_after", 8'h81, get_data);
    $display("stop test done");
  endtask : t_stop
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {rst, err_total, samples_checked, cyc} = {1'b1, 96'h0};
    {sel_wr, mode_wr, put_wr, clock_stop, arm, slave, talk} = 7'h0;
    {sel_wdata, mode_wdata, put_data, ptx} = 24'h0;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_codes();
    t_master();
    t_slave();
    t_stop();
    tally_and_finish();
  end
endmodule : csio_tb_top
`default_nettype wire

// *** core/csio_clkgen.sv ***
// internal shift clock generator for master operation
`timescale 1ns/100ps
`default_nettype none
module csio_clkgen
  import csio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  csio_div_if.gen div
);

  // ************************************************************
  // half period counter and clock level
  // ************************************************************
  logic [CSIO_HALF_W-1:0] tick_cnt; // cycles in this half period
  logic sck_q; // generated level
  wire half_done = (tick_cnt >= div.half - 1'b1);

  assign div.sck_level = sck_q;

  // idle high, toggle each half period while running; the first
  // edge after release is a fall, so the first bit follows it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      sck_q <= 1'b1;
    end else if (!div.run) begin
      tick_cnt <= '0;
      sck_q <= 1'b1;
    end else if (half_done) begin
      tick_cnt <= '0;
      sck_q <= ~sck_q;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

endmodule : csio_clkgen
`default_nettype wire

// *** core/csio_div_if.sv ***
// link between the unit's control logic and its shift clock generator
`timescale 1ns/100ps
`default_nettype none
interface csio_div_if;
  import csio_pkg::*;
  logic run; // generator may toggle the clock
  logic [CSIO_HALF_W-1:0] half; // half period in cycles
  logic sck_level; // generated clock level

  // control side drives run and rate
  modport ctrl (output run, output half, input sck_level);
  // generator side
  modport gen (input run, input half, output sck_level);
endinterface : csio_div_if
`default_nettype wire

// *** core/csio_pkg.sv ***
// constants, encodings and timing for the clocked serial i/o unit
package csio_pkg;

  // ************************************************************
  // register addresses and field positions
  // ************************************************************
  localparam logic [7:0] CSIO_ADDR_CLK_SEL = 8'h1C; // clock select
  localparam logic [7:0] CSIO_ADDR_MODE = 8'h1D; // mode select
  localparam int CSIO_BIT_RUN = 0; // transfer_run
  localparam int CSIO_BIT_HIZ = 1; // dedicated_output_enable
  localparam int CSIO_BIT_DIR = 3; // data_direction_select
  localparam int CSIO_BIT_CKL = 0; // clock_select_low
  localparam int CSIO_BIT_CKH = 1; // clock_select_high

  // ************************************************************
  // transfer shape
  // ************************************************************
  localparam int CSIO_DATA_W = 8; // shift register width
  localparam logic [3:0] CSIO_CNT_ZERO = 4'h0; // counter start
  localparam logic [3:0] CSIO_CNT_LAST = 4'h8; // end of byte
  localparam logic [3:0] CSIO_CNT_ONE = 4'h1; // increment
  localparam logic [7:0] CSIO_SR_RESET = 8'h00; // shift reg reset

  // clock select codes
  typedef enum logic [1:0] {
    CSIO_CK_EXT = 2'h0,
    CSIO_CK_SLOW = 2'h1,
    CSIO_CK_MID = 2'h2,
    CSIO_CK_FAST = 2'h3
  } csio_ck_t;

  // ************************************************************
  // timing: rates in hundredths of a hertz, sys clock in hertz
  // ************************************************************
  localparam longint CSIO_SYS_HZ = 50000000;
  localparam longint CSIO_SLOW_CHZ = 1250000; // 12.5 kHz
  localparam longint CSIO_MID_CHZ = 1875000; // 18.75 kHz
  localparam longint CSIO_FAST_CHZ = 3750000; // 37.5 kHz
  localparam int CSIO_HALF_W = 12; // half period counter width

  // half period in cycles, rounded down so the rate never falls short
  function automatic logic [CSIO_HALF_W-1:0] csio_half(input longint chz);
    longint h;
    h = (CSIO_SYS_HZ * 100) / (2 * chz);
    csio_half = h[CSIO_HALF_W-1:0];
  endfunction : csio_half

  localparam logic [CSIO_HALF_W-1:0] CSIO_HALF_SLOW = csio_half(CSIO_SLOW_CHZ);
  localparam logic [CSIO_HALF_W-1:0] CSIO_HALF_MID = csio_half(CSIO_MID_CHZ);
  localparam logic [CSIO_HALF_W-1:0] CSIO_HALF_FAST = csio_half(CSIO_FAST_CHZ);

endpackage : csio_pkg

// *** core/csio_top.sv ***
// clocked serial i/o unit: flags, shift register, counter and pins
`timescale 1ns/100ps
`default_nettype none
module csio_top
  import csio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  // clock select register write and readback
  input wire logic sel_wr,
  input wire logic [3:0] sel_wdata,
  output logic [3:0] sel_rdata,
  // mode select register write and readback
  input wire logic mode_wr,
  input wire logic [3:0] mode_wdata,
  output logic [3:0] mode_rdata,
  // data buffer transfers to and from the shift register
  input wire logic put_wr,
  input wire logic [7:0] put_data,
  output logic [7:0] get_data,
  // clock stop instruction
  input wire logic clock_stop,
  // transfer complete request to the interrupt controller
  output logic irq,
  // shift clock pin
  input wire logic sck_clk,
  output logic sck_out,
  output logic sck_oe,
  // shared data pin
  input wire logic shared_in,
  output logic shared_out,
  output logic shared_oe,
  // dedicated data output pin
  output logic dedicated_out,
  output logic dedicated_oe
);

  // ************************************************************
  // link domain: edges of the clock pin itself
  // ************************************************************
  // the counter looks at the pin, so master and slave clocks look
  // alike; each edge becomes a toggle that the sys domain syncs
  logic rise_tgl; // flips on every rising edge of the pin
  logic fall_tgl; // flips on every falling edge of the pin
  logic cap_bit; // shared pin captured at the rising edge

  // rising edge: capture the serial input and mark the event
  always_ff @(posedge sck_clk or posedge rst) begin
    if (rst) begin
      rise_tgl <= 1'b0;
      cap_bit <= 1'b0;
    end else begin
      rise_tgl <= ~rise_tgl;
      cap_bit <= shared_in;
    end
  end

  // falling edge: mark the event only
  always_ff @(negedge sck_clk or posedge rst) begin
    if (rst) begin
      fall_tgl <= 1'b0;
    end else begin
      fall_tgl <= ~fall_tgl;
    end
  end

  // ************************************************************
  // crossing into the sys domain
  // ************************************************************
  logic rise_s1; // first stage, read only by rise_s2
  logic rise_s2; // synchronised rise toggle
  logic rise_s3; // previous value for edge detect
  logic fall_s1; // first stage, read only by fall_s2
  logic fall_s2; // synchronised fall toggle
  logic fall_s3; // previous value for edge detect

  // two flops per toggle, a third for the change detect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rise_s1 <= 1'b0;
      rise_s2 <= 1'b0;
      rise_s3 <= 1'b0;
      fall_s1 <= 1'b0;
      fall_s2 <= 1'b0;
      fall_s3 <= 1'b0;
    end else begin
      rise_s1 <= rise_tgl;
      rise_s2 <= rise_s1;
      rise_s3 <= rise_s2;
      fall_s1 <= fall_tgl;
      fall_s2 <= fall_s1;
      fall_s3 <= fall_s2;
    end
  end

  wire rise_ev = rise_s2 ^ rise_s3;
  wire fall_ev = fall_s2 ^ fall_s3;

  // ************************************************************
  // control flags
  // ************************************************************
  csio_ck_t clk_sel; // clock source and rate
  logic run; // transfer_run: wait released
  logic hiz; // dedicated_output_enable
  logic dir; // data_direction_select
  logic sck_low; // last pin edge seen was a fall

  // decoded write fields
  wire [1:0] sel_field = {sel_wdata[CSIO_BIT_CKH], sel_wdata[CSIO_BIT_CKL]};
  wire wr_run = mode_wdata[CSIO_BIT_RUN];
  wire wr_hiz = mode_wdata[CSIO_BIT_HIZ];
  wire wr_dir = mode_wdata[CSIO_BIT_DIR];

  // a zero written while running forces the wait state
  wire force_wait = mode_wr && !wr_run && run;
  // a one written from wait starts a transfer
  wire start = mode_wr && wr_run && !run;
  // rise with the count at eight ends the transfer
  logic [3:0] bit_cnt; // shift clock counter, never readable
  wire at_last = (bit_cnt == CSIO_CNT_LAST);
  wire end_xfer = run && rise_ev && at_last;
  wire master = (clk_sel != CSIO_CK_EXT);

  // flag registers; hardware end of transfer wins over a software
  // restart in the same cycle is impossible since start needs wait
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_sel <= CSIO_CK_EXT;
      run <= 1'b0;
      hiz <= 1'b0;
      dir <= 1'b0;
    end else begin
      // clock write may share the cycle with a start
      // rate is not changed while running
      if (sel_wr && !run) begin
        clk_sel <= csio_ck_t'(sel_field);
      end
      if (mode_wr) begin
        hiz <= wr_hiz;
        dir <= wr_dir;
      end
      if (clock_stop) begin
        // stop instruction returns to wait
        run <= 1'b0;
      end else if (end_xfer) begin
        run <= 1'b0;
      end else if (force_wait) begin
        run <= 1'b0;
      end else if (start) begin
        run <= 1'b1;
      end
    end
  end

  // pin level as seen through the edge events, used for loads
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_low <= 1'b0;
    end else if (fall_ev) begin
      sck_low <= 1'b1;
    end else if (rise_ev) begin
      sck_low <= 1'b0;
    end
  end

  // ************************************************************
  // shift clock counter
  // ************************************************************
  // counts falls while running; a restart write while running
  // leaves it untouched
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= CSIO_CNT_ZERO;
    end else if (clock_stop || force_wait || end_xfer) begin
      // cleared by stop, forced wait or end of byte
      bit_cnt <= CSIO_CNT_ZERO;
    end else if (run && fall_ev && !at_last) begin
      bit_cnt <= bit_cnt + CSIO_CNT_ONE;
    end
  end

  // ************************************************************
  // shift register and serial output latch
  // ************************************************************
  logic [CSIO_DATA_W-1:0] shift_data; // serial_shift_data
  logic out_bit; // serial output latch
  logic irq_q; // one cycle request

  // two-wire output mode reads back its own output latch
  wire two_wire = !hiz;
  wire loop_in = two_wire && dir;
  wire in_bit = loop_in ? out_bit : cap_bit;
  // load while running with the clock low shows the msb
  wire load_live = put_wr && run && sck_low;
  wire shift_fall = run && fall_ev && !at_last;
  wire shift_rise = run && rise_ev;

  // the captured bit is a held word: it is stable from the rise
  // until the next rise, so the synced rise event may read it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_data <= CSIO_SR_RESET;
    end else if (put_wr) begin
      // software load through the data buffer
      // in wait the byte simply waits for a fall
      shift_data <= put_data;
    end else if (shift_rise) begin
      // shift left, serial input into the lsb
      shift_data <= {shift_data[CSIO_DATA_W-2:0], in_bit};
    end
  end

  // output latch: msb on each fall, or at once on a live load
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_bit <= 1'b0;
    end else if (load_live) begin
      // new msb straight to the pin
      out_bit <= put_data[CSIO_DATA_W-1];
    end else if (shift_fall) begin
      // msb out on the falling edge
      out_bit <= shift_data[CSIO_DATA_W-1];
    end
  end

  // completion request, one sys cycle wide
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= end_xfer;
    end
  end

  // ************************************************************
  // internal clock generator
  // ************************************************************
  csio_div_if div ();
  logic [CSIO_HALF_W-1:0] half_sel; // half period for the rate

  always_comb begin
    unique case (clk_sel)
      CSIO_CK_SLOW: half_sel = CSIO_HALF_SLOW;
      CSIO_CK_MID: half_sel = CSIO_HALF_MID;
      CSIO_CK_FAST: half_sel = CSIO_HALF_FAST;
      CSIO_CK_EXT: half_sel = CSIO_HALF_SLOW;
    endcase
  end

  // generator runs only for a master transfer
  assign div.run = run && master;
  assign div.half = half_sel;

  csio_clkgen u_clkgen (
    .sys_clk(sys_clk),
    .rst(rst),
    .div(div)
  );

  // ************************************************************
  // pin drivers and readback, all from flops
  // ************************************************************
  // two-wire direction flag chooses shared pin role
  wire shared_drv = two_wire && dir;
  // three-wire drives the dedicated pin, reads shared
  wire ded_drv = hiz;
  // readback holds only flags, never the counter
  wire [3:0] sel_view = {2'h0, clk_sel};
  wire [3:0] mode_view = {dir, 1'b0, hiz, run};

  // output registers; the shift clock pin is driven only as master
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
      shared_out <= 1'b0;
      shared_oe <= 1'b0;
      dedicated_out <= 1'b0;
      dedicated_oe <= 1'b0;
      sel_rdata <= 4'h0;
      mode_rdata <= 4'h0;
      get_data <= CSIO_SR_RESET;
      irq <= 1'b0;
    end else begin
      // high in wait, generator idles high
      sck_out <= div.sck_level;
      sck_oe <= master;
      shared_out <= out_bit;
      shared_oe <= shared_drv;
      dedicated_out <= out_bit;
      dedicated_oe <= ded_drv;
      sel_rdata <= sel_view;
      mode_rdata <= mode_view;
      get_data <= shift_data;
      irq <= irq_q;
    end
  end

endmodule : csio_top
`default_nettype wire
